/* rtu_io_pkg.sv */
// Shared constants, register map and state encodings for the field I/O core
package rtu_io_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int unsigned CLOCK_HZ = 20_000_000;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned S_PER_MIN = 60;
  localparam int unsigned MS_CYCLES = CLOCK_HZ / MS_PER_S;
  localparam int unsigned SETTLE_TIME_MS = 400;
  localparam int unsigned SAMPLE_PERIOD_S = 5;
  localparam int unsigned TEST_HOLD_MIN = 5;
  localparam int unsigned MOMENT_TIME_MS = 1000;
  localparam int unsigned REPORT_LIMIT_DEF = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values of the programmable registers; the four times are in milliseconds
  localparam logic [31:0] SETTLE_RESET = 32'(SETTLE_TIME_MS);
  localparam logic [31:0] PERIOD_RESET = 32'(SAMPLE_PERIOD_S * MS_PER_S);
  localparam logic [31:0] HOLD_RESET = 32'(TEST_HOLD_MIN * S_PER_MIN * MS_PER_S);
  localparam logic [31:0] MOMENT_RESET = 32'(MOMENT_TIME_MS);
  localparam logic [15:0] LIMIT_RESET = 16'(REPORT_LIMIT_DEF);
  localparam logic [15:0] DI_CFG_RESET = 16'h0000;
  localparam logic [4:0] CTRL_RESET = 5'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Register word addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PULSE_CMD = 8'h01;
  localparam logic [7:0] ADDR_SETTLE = 8'h02;
  localparam logic [7:0] ADDR_PERIOD = 8'h03;
  localparam logic [7:0] ADDR_HOLD = 8'h04;
  localparam logic [7:0] ADDR_MOMENT = 8'h05;
  localparam logic [7:0] ADDR_DI_CFG = 8'h06;
  localparam logic [7:0] ADDR_LIMIT = 8'h07;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_EVENTS = 8'h09;
  localparam logic [7:0] ADDR_PAIR1_COUNT = 8'h0a;
  localparam logic [7:0] ADDR_PAIR2_COUNT = 8'h0b;
  localparam logic [7:0] ADDR_TS_INDEX = 8'h0c;
  localparam logic [7:0] ADDR_TS_DATA = 8'h0d;
  localparam logic [7:0] ADDR_STATS_CLEAR = 8'h0e;
  localparam logic [4:0] ADDR_ACCUM_BASE = 5'h02;
  localparam logic [2:0] ADDR_STATS_BASE = 3'h1;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int unsigned CTRL_HIGH_SIDE = 0;
  localparam int unsigned CTRL_LOW_A = 1;
  localparam int unsigned CTRL_LOW_B = 2;
  localparam int unsigned CTRL_PAIR1_EN = 3;
  localparam int unsigned CTRL_PAIR2_EN = 4;
  localparam int unsigned STATUS_SUPPLY = 8;
  localparam int unsigned STATUS_HOLD = 9;
  localparam int unsigned STATUS_BUSY = 10;
  localparam logic [1:0] STAT_MIN = 2'h0;
  localparam logic [1:0] STAT_MAX = 2'h1;
  localparam logic [1:0] STAT_AVG = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Channel counts and status input modes
  localparam int unsigned NUM_DI = 8;
  localparam int unsigned NUM_CH = 5;
  localparam logic [2:0] BATT_CH = 3'h4;
  localparam int unsigned AVG_SHIFT = 3;
  localparam logic [1:0] DI_FORM_A = 2'h0;
  localparam logic [1:0] DI_FORM_B = 2'h1;
  localparam logic [1:0] DI_FORM_C = 2'h2;
  localparam logic [1:0] DI_ACCUM = 2'h3;

  typedef enum logic [3:0] {
    SEQ_IDLE = 4'b0001,
    SEQ_SETTLE = 4'b0010,
    SEQ_CONVERT = 4'b0100,
    SEQ_WAIT = 4'b1000
  } seq_state_e;

  typedef enum logic [2:0] {
    PAIR_IDLE = 3'b001,
    PAIR_Z_LOW = 3'b010,
    PAIR_Y_LOW = 3'b100
  } pair_state_e;

endpackage

/* transition_stamp_memory.sv */
// Small memory holding the millisecond stamp of each status input's last change
`timescale 1ns/1ps
`default_nettype none

module transition_stamp_memory #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 8
) (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_wr_en,
  input wire logic [$clog2(DEPTH)-1:0] i_wr_addr,
  input wire logic [WIDTH-1:0] i_wr_data,
  input wire logic [$clog2(DEPTH)-1:0] i_rd_addr,
  output logic [WIDTH-1:0] o_rd_data
);

  logic [WIDTH-1:0] mem_q [DEPTH];

  // Array left without reset so it maps onto plain storage
  always_ff @(posedge i_clock)
  begin
    if (i_wr_en)
    begin
      mem_q[i_wr_addr] <= i_wr_data;
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_reset_n)
    begin
      o_rd_data <= '0;
    end
    else
    begin
      o_rd_data <= mem_q[i_rd_addr];
    end
  end

endmodule

`default_nettype wire

/* rtu_io_sampling_sequencer.sv */
// Field I/O core: sensor supply sequencing, analog statistics, status inputs, outputs
//
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none

module rtu_io_sampling_sequencer
  import rtu_io_pkg::*;
#(
  parameter int unsigned MS_TICKS = MS_CYCLES,
  parameter int unsigned ADC_WIDTH = 12
) (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wr_data,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  output logic [31:0] o_rd_data,
  input wire logic i_test_button,
  input wire logic [NUM_DI-1:0] i_status_in,
  output logic o_adc_start,
  output logic [2:0] o_adc_channel,
  input wire logic i_adc_done,
  input wire logic [ADC_WIDTH-1:0] i_adc_data,
  output logic o_sensor_supply,
  output logic o_supply_indicator,
  input wire logic i_rx_activity,
  input wire logic i_tx_activity,
  output logic o_rx_indicator,
  output logic o_tx_indicator,
  output logic o_high_side_output,
  output logic o_high_side_output_oe_n,
  output logic o_low_side_output_a,
  output logic o_low_side_output_a_oe_n,
  output logic o_low_side_output_b,
  output logic o_low_side_output_b_oe_n
);

  localparam int unsigned TW = $clog2(MS_TICKS + 1);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [ADC_WIDTH-1:0] ema(input logic [ADC_WIDTH-1:0] avg,
                                                input logic [ADC_WIDTH-1:0] x);
    logic signed [ADC_WIDTH+1:0] d;
    logic signed [ADC_WIDTH+1:0] r;
    d = $signed({2'b00, x}) - $signed({2'b00, avg});
    r = $signed({2'b00, avg}) + (d >>> AVG_SHIFT);
    return r[ADC_WIDTH-1:0];
  endfunction

  function automatic pair_state_e pair_step(input pair_state_e s, input logic z, input logic y);
    pair_state_e n;
    n = s;
    unique case (s)
      PAIR_IDLE: if (!z && y) n = PAIR_Z_LOW;
      PAIR_Z_LOW: if (!y && !z) n = PAIR_Y_LOW; else if (z) n = PAIR_IDLE;
      PAIR_Y_LOW: if (z || y) n = PAIR_IDLE;
    endcase
    return n;
  endfunction

  function automatic logic [31:0] count_down(input logic [31:0] c, input logic tick);
    return (tick && c != 32'h0) ? c - 32'h1 : c;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Millisecond time base
  logic [TW-1:0] tick_cnt_q;
  logic [15:0] ms_stamp_q;
  wire ms_tick = (tick_cnt_q == TW'(MS_TICKS - 1));

  always_ff @(posedge i_clock)
  begin
    if (!i_reset_n)
    begin
      tick_cnt_q <= '0;
      ms_stamp_q <= 16'h0;
    end
    else
    begin
      tick_cnt_q <= ms_tick ? '0 : tick_cnt_q + TW'(1);
      ms_stamp_q <= ms_stamp_q + {15'h0, ms_tick};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes
  logic [4:0] ctrl_q;
  logic [31:0] settle_q, period_q, hold_q, moment_q;
  logic [15:0] di_cfg_q, limit_q;
  logic [2:0] ts_index_q;
  wire wr_ctrl = i_wr_en && i_addr == ADDR_CTRL;
  wire wr_pulse = i_wr_en && i_addr == ADDR_PULSE_CMD;
  wire wr_events = i_wr_en && i_addr == ADDR_EVENTS;
  wire wr_pair1 = i_wr_en && i_addr == ADDR_PAIR1_COUNT;
  wire wr_pair2 = i_wr_en && i_addr == ADDR_PAIR2_COUNT;
  wire wr_stats_clr = i_wr_en && i_addr == ADDR_STATS_CLEAR;

  always_ff @(posedge i_clock)
  begin
    if (!i_reset_n)
    begin
      ctrl_q <= CTRL_RESET;
      settle_q <= SETTLE_RESET;
      period_q <= PERIOD_RESET;
      hold_q <= HOLD_RESET;
      moment_q <= MOMENT_RESET;
      di_cfg_q <= DI_CFG_RESET;
      limit_q <= LIMIT_RESET;
      ts_index_q <= 3'h0;
    end
    else if (i_wr_en)
    begin
      if (wr_ctrl) ctrl_q <= i_wr_data[4:0];
      if (i_addr == ADDR_SETTLE) settle_q <= i_wr_data;
      if (i_addr == ADDR_PERIOD) period_q <= i_wr_data;
      if (i_addr == ADDR_HOLD) hold_q <= i_wr_data;
      if (i_addr == ADDR_MOMENT) moment_q <= i_wr_data;
      if (i_addr == ADDR_DI_CFG) di_cfg_q <= i_wr_data[15:0];
      if (i_addr == ADDR_LIMIT) limit_q <= i_wr_data[15:0];
      if (i_addr == ADDR_TS_INDEX) ts_index_q <= i_wr_data[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sample sequencer
  seq_state_e seq_q, seq_d;
  logic [31:0] period_cnt_q, settle_cnt_q, hold_cnt_q;
  logic [2:0] ch_q;
  logic test_prev_q;
  wire period_due = ms_tick && period_cnt_q + 32'h1 >= period_q;
  wire settle_done = settle_cnt_q >= settle_q;
  wire conv_done = seq_q == SEQ_WAIT && i_adc_done;
  wire last_ch = ch_q == BATT_CH;
  wire test_press = i_test_button && !test_prev_q;
  wire [31:0] hold_cnt_d = test_press ? hold_q : count_down(hold_cnt_q, ms_tick);
  wire pulse_on_d = seq_d != SEQ_IDLE;
  wire supply_d = pulse_on_d || hold_cnt_d != 32'h0;

  always_comb
  begin
    seq_d = seq_q;
    unique case (seq_q)
      SEQ_IDLE: if (period_due) seq_d = SEQ_SETTLE;
      SEQ_SETTLE: if (settle_done) seq_d = SEQ_CONVERT;
      SEQ_CONVERT: seq_d = SEQ_WAIT;
      SEQ_WAIT: if (i_adc_done) seq_d = last_ch ? SEQ_IDLE : SEQ_CONVERT;
      default: seq_d = SEQ_IDLE;
    endcase
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_reset_n)
    begin
      seq_q <= SEQ_IDLE;
      period_cnt_q <= 32'h0;
      settle_cnt_q <= 32'h0;
      hold_cnt_q <= 32'h0;
      ch_q <= 3'h0;
      test_prev_q <= 1'b0;
    end
    else
    begin
      seq_q <= seq_d;
      period_cnt_q <= period_due ? 32'h0 : period_cnt_q + {31'h0, ms_tick};
      settle_cnt_q <= seq_q == SEQ_SETTLE ? settle_cnt_q + {31'h0, ms_tick} : 32'h0;
      hold_cnt_q <= hold_cnt_d;
      ch_q <= seq_q == SEQ_IDLE ? 3'h0 : ch_q + {2'h0, conv_done && !last_ch};
      test_prev_q <= i_test_button;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Analog statistics
  logic [ADC_WIDTH-1:0] min_q [NUM_CH];
  logic [ADC_WIDTH-1:0] max_q [NUM_CH];
  logic [ADC_WIDTH-1:0] avg_q [NUM_CH];
  logic [NUM_CH-1:0] seen_q;

  always_ff @(posedge i_clock)
  begin
    if (!i_reset_n)
    begin
      seen_q <= '0;
      for (int i = 0; i < NUM_CH; i++)
      begin
        min_q[i] <= '0;
        max_q[i] <= '0;
        avg_q[i] <= '0;
      end
    end
    else if (wr_stats_clr)
    begin
      seen_q <= '0;
    end
    else if (conv_done)
    begin
      seen_q[ch_q] <= 1'b1;
      min_q[ch_q] <= (!seen_q[ch_q] || i_adc_data < min_q[ch_q]) ? i_adc_data : min_q[ch_q];
      max_q[ch_q] <= (!seen_q[ch_q] || i_adc_data > max_q[ch_q]) ? i_adc_data : max_q[ch_q];
      avg_q[ch_q] <= seen_q[ch_q] ? ema(avg_q[ch_q], i_adc_data) : i_adc_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status inputs, accumulators and event flags
  logic [NUM_DI-1:0] di_prev_q, pending_q, event_q;
  logic [15:0] accum_q [NUM_DI];
  logic [15:0] since_q [NUM_DI];
  logic [NUM_DI-1:0] di_state, accum_ev, change_ev;
  logic [2:0] ts_wr_idx;
  logic ts_wr_en;
  wire [NUM_DI-1:0] di_change = i_status_in ^ di_prev_q;

  always_comb
  begin
    ts_wr_en = 1'b0;
    ts_wr_idx = 3'h0;
    for (int i = NUM_DI - 1; i >= 0; i--)
    begin
      // Closed contact pulls low; Form B reports the opposite sense
      di_state[i] = di_cfg_q[2*i +: 2] == DI_FORM_B ? i_status_in[i] : !i_status_in[i];
      change_ev[i] = di_change[i] && di_cfg_q[2*i +: 2] != DI_ACCUM;
      accum_ev[i] = di_cfg_q[2*i +: 2] == DI_ACCUM && di_change[i] && !i_status_in[i]
                    && since_q[i] + 16'h1 >= limit_q;
      if (pending_q[i])
      begin
        ts_wr_en = 1'b1;
        ts_wr_idx = 3'(i);
      end
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_reset_n)
    begin
      di_prev_q <= '0;
      pending_q <= '0;
      event_q <= '0;
      for (int i = 0; i < NUM_DI; i++)
      begin
        accum_q[i] <= 16'h0;
        since_q[i] <= 16'h0;
      end
    end
    else
    begin
      di_prev_q <= i_status_in;
      // Backlog drains one input per cycle, far inside a millisecond
      pending_q <= (pending_q & ~(ts_wr_en ? 8'h01 << ts_wr_idx : 8'h00)) | di_change;
      event_q <= (event_q & ~(wr_events ? i_wr_data[7:0] : 8'h00)) | change_ev | accum_ev;
      for (int i = 0; i < NUM_DI; i++)
      begin
        if (di_cfg_q[2*i +: 2] == DI_ACCUM && di_change[i] && !i_status_in[i])
        begin
          accum_q[i] <= accum_q[i] + 16'h1;
          since_q[i] <= accum_ev[i] ? 16'h0 : since_q[i] + 16'h1;
        end
      end
    end
  end

  logic [15:0] ts_rd_data;

  transition_stamp_memory #(
    .WIDTH(16),
    .DEPTH(NUM_DI)
  ) u_stamps (
    .i_clock(i_clock),
    .i_reset_n(i_reset_n),
    .i_wr_en(ts_wr_en),
    .i_wr_addr(ts_wr_idx),
    .i_wr_data(ms_stamp_q),
    .i_rd_addr(ts_index_q),
    .o_rd_data(ts_rd_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Meter pulse pairs
  pair_state_e pair1_q, pair2_q;
  logic [31:0] pair1_cnt_q, pair2_cnt_q;
  wire pulse_pair1_z_leg = i_status_in[4];
  wire pulse_pair1_y_leg = i_status_in[5];
  wire pulse_pair2_z_leg = i_status_in[6];
  wire pulse_pair2_y_leg = i_status_in[7];
  wire pair1_en = ctrl_q[CTRL_PAIR1_EN];
  wire pair2_en = ctrl_q[CTRL_PAIR2_EN];
  wire pair1_hit = pair1_en && pair1_q == PAIR_Y_LOW && pulse_pair1_z_leg && !pulse_pair1_y_leg;
  wire pair2_hit = pair2_en && pair2_q == PAIR_Y_LOW && pulse_pair2_z_leg && !pulse_pair2_y_leg;

  always_ff @(posedge i_clock)
  begin
    if (!i_reset_n)
    begin
      pair1_q <= PAIR_IDLE;
      pair2_q <= PAIR_IDLE;
      pair1_cnt_q <= 32'h0;
      pair2_cnt_q <= 32'h0;
    end
    else
    begin
      pair1_q <= pair1_en ? pair_step(pair1_q, pulse_pair1_z_leg, pulse_pair1_y_leg) : PAIR_IDLE;
      pair2_q <= pair2_en ? pair_step(pair2_q, pulse_pair2_z_leg, pulse_pair2_y_leg) : PAIR_IDLE;
      // A count landing with the clear is kept
      pair1_cnt_q <= (wr_pair1 ? 32'h0 : pair1_cnt_q) + {31'h0, pair1_hit};
      pair2_cnt_q <= (wr_pair2 ? 32'h0 : pair2_cnt_q) + {31'h0, pair2_hit};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux
  logic [31:0] rd_mux;
  wire [2:0] stat_ch = i_addr[4:2];
  wire [1:0] stat_kind = i_addr[1:0];
  wire is_stat = i_addr[7:5] == ADDR_STATS_BASE && stat_ch < 3'(NUM_CH);
  wire is_accum = i_addr[7:3] == ADDR_ACCUM_BASE;

  always_comb
  begin
    rd_mux = 32'h0;
    if (is_stat)
    begin
      if (stat_kind == STAT_MIN) rd_mux = 32'(min_q[stat_ch]);
      else if (stat_kind == STAT_MAX) rd_mux = 32'(max_q[stat_ch]);
      else if (stat_kind == STAT_AVG) rd_mux = 32'(avg_q[stat_ch]);
    end
    else if (is_accum)
    begin
      rd_mux = {16'h0, accum_q[i_addr[2:0]]};
    end
    else
    begin
      case (i_addr)
        ADDR_CTRL: rd_mux = {27'h0, ctrl_q};
        ADDR_SETTLE: rd_mux = settle_q;
        ADDR_PERIOD: rd_mux = period_q;
        ADDR_HOLD: rd_mux = hold_q;
        ADDR_MOMENT: rd_mux = moment_q;
        ADDR_DI_CFG: rd_mux = {16'h0, di_cfg_q};
        ADDR_LIMIT: rd_mux = {16'h0, limit_q};
        ADDR_STATUS: rd_mux = {21'h0, seq_q != SEQ_IDLE, hold_cnt_q != 32'h0,
                               o_sensor_supply, di_state};
        ADDR_EVENTS: rd_mux = {24'h0, event_q};
        ADDR_PAIR1_COUNT: rd_mux = pair1_cnt_q;
        ADDR_PAIR2_COUNT: rd_mux = pair2_cnt_q;
        ADDR_TS_INDEX: rd_mux = {29'h0, ts_index_q};
        ADDR_TS_DATA: rd_mux = {16'h0, ts_rd_data};
        default: rd_mux = 32'h0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output flops
  logic [31:0] moment_a_q, moment_b_q;
  wire sink_a_d = ctrl_q[CTRL_LOW_A] || moment_a_q != 32'h0;
  wire sink_b_d = ctrl_q[CTRL_LOW_B] || moment_b_q != 32'h0;

  always_ff @(posedge i_clock)
  begin
    if (!i_reset_n)
    begin
      moment_a_q <= 32'h0;
      moment_b_q <= 32'h0;
      o_rd_data <= 32'h0;
      o_adc_start <= 1'b0;
      o_adc_channel <= 3'h0;
      o_sensor_supply <= 1'b0;
      o_supply_indicator <= 1'b0;
      o_rx_indicator <= 1'b0;
      o_tx_indicator <= 1'b0;
      o_high_side_output <= 1'b0;
      o_high_side_output_oe_n <= 1'b1;
      o_low_side_output_a <= 1'b0;
      o_low_side_output_a_oe_n <= 1'b1;
      o_low_side_output_b <= 1'b0;
      o_low_side_output_b_oe_n <= 1'b1;
    end
    else
    begin
      moment_a_q <= wr_pulse && i_wr_data[0] ? moment_q : count_down(moment_a_q, ms_tick);
      moment_b_q <= wr_pulse && i_wr_data[1] ? moment_q : count_down(moment_b_q, ms_tick);
      o_rd_data <= i_rd_en ? rd_mux : 32'h0;
      o_adc_start <= seq_q == SEQ_CONVERT;
      o_adc_channel <= ch_q;
      o_sensor_supply <= supply_d;
      o_supply_indicator <= supply_d;
      o_rx_indicator <= supply_d && i_rx_activity;
      o_tx_indicator <= supply_d && i_tx_activity;
      o_high_side_output <= ctrl_q[CTRL_HIGH_SIDE];
      o_high_side_output_oe_n <= !ctrl_q[CTRL_HIGH_SIDE];
      o_low_side_output_a <= 1'b0;
      o_low_side_output_a_oe_n <= !sink_a_d;
      o_low_side_output_b <= 1'b0;
      o_low_side_output_b_oe_n <= !sink_b_d;
    end
  end

endmodule

`default_nettype wire

/* none.sv */
// Intentionally empty
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* rtu_io_sampling_sequencer_assertions.sv */
// Port-level checks for the field I/O core
`timescale 1ns/1ps
`default_nettype none
module rtu_io_sampling_sequencer_assertions
  import rtu_io_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic o_adc_start,
  input wire logic [2:0] o_adc_channel,
  input wire logic i_adc_done,
  input wire logic o_sensor_supply,
  input wire logic o_supply_indicator,
  input wire logic o_rx_indicator,
  input wire logic o_tx_indicator,
  input wire logic o_high_side_output,
  input wire logic o_high_side_output_oe_n,
  input wire logic o_low_side_output_a,
  input wire logic o_low_side_output_a_oe_n,
  input wire logic o_low_side_output_b
);
  default clocking dc @(posedge i_clock);
  endclocking
  default disable iff (!i_reset_n);
  ////////////////////////////////////////
  property p_ind;
    o_supply_indicator == o_sensor_supply;
  endproperty
  a_ind: assert property (p_ind) else $error("lamp differs from supply");
  property p_lamps;
    (o_rx_indicator || o_tx_indicator) |-> o_sensor_supply;
  endproperty
  a_lamps: assert property (p_lamps) else $error("serial lamp unpowered");
  // Settle of at least one ms tick in simulation
  property p_settled;
    o_adc_start |-> o_sensor_supply && $past(o_sensor_supply, 4);
  endproperty
  a_settled: assert property (p_settled) else $error("start before settle");
  property p_one;
    o_adc_start |=> !o_adc_start;
  endproperty
  a_one: assert property (p_one) else $error("start pulse too long");
  property p_range;
    o_adc_start |-> o_adc_channel <= BATT_CH;
  endproperty
  a_range: assert property (p_range) else $error("bad channel");
  property p_next;
    (i_adc_done && o_adc_channel != BATT_CH)
      |-> ##2 (o_adc_start && o_adc_channel == $past(o_adc_channel, 2) + 3'h1);
  endproperty
  a_next: assert property (p_next) else $error("next channel late");
  property p_hs;
    o_high_side_output_oe_n == !o_high_side_output;
  endproperty
  a_hs: assert property (p_hs) else $error("high side enable wrong");
  property p_low;
    !o_low_side_output_a && !o_low_side_output_b;
  endproperty
  a_low: assert property (p_low) else $error("low side not sinking");
  c_last: cover property (o_adc_start && o_adc_channel == BATT_CH);
  c_pulse: cover property ($fell(o_low_side_output_a_oe_n));
  c_lamps: cover property (o_rx_indicator && o_tx_indicator);
endmodule
bind rtu_io_sampling_sequencer rtu_io_sampling_sequencer_assertions i_checker (.*);
`default_nettype wire

/* field_side_model.sv */
// Field-side converter model: answers each start with done and data
`timescale 1ns/1ps
`default_nettype none
module field_side_model #(
  parameter int FAST = 2,
  parameter int SLOW = 12
) (
  input wire logic i_clock,
  input wire logic i_start,
  input wire logic [2:0] i_channel,
  input wire logic i_slow,
  output logic o_done,
  output logic [11:0] o_data
);
  int left_q = 0;
  logic done_q = 1'b0;
  logic [4:0] count_q = 5'h00;
  logic [11:0] data_q = 12'h5a5;
  assign o_done = done_q;
  assign o_data = data_q;
  always_ff @(posedge i_clock)
  begin
    done_q <= (left_q == 1);
    // Toggles outside done so a stale value never passes
    data_q <= (left_q == 1) ? {i_channel, count_q, 4'h0} : ~data_q;
    count_q <= count_q + 5'(left_q == 1);
    left_q <= i_start ? (i_slow ? SLOW : FAST) : (left_q > 0 ? left_q - 1 : 0);
  end
endmodule
`default_nettype wire

/* tb_top.sv */
// Self-checking bench for the field I/O core
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import rtu_io_pkg::*;
  logic i_clock = 1'b0;
  logic i_reset_n = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wr_data = 32'h0;
  logic i_wr_en = 1'b0;
  logic i_rd_en = 1'b0;
  logic i_test_button = 1'b0;
  logic [7:0] i_status_in = 8'hff;
  logic i_rx_activity = 1'b0;
  logic i_tx_activity = 1'b0;
  logic slow = 1'b0;
  logic i_adc_done, o_adc_start, o_sensor_supply, o_supply_indicator;
  logic [11:0] i_adc_data;
  logic [31:0] o_rd_data;
  logic [2:0] o_adc_channel;
  logic o_rx_indicator, o_tx_indicator, o_high_side_output, o_high_side_output_oe_n;
  logic o_low_side_output_a, o_low_side_output_a_oe_n, o_low_side_output_b;
  logic o_low_side_output_b_oe_n;
  int fails = 0;
  int checked = 0;
  // Short ms tick keeps every timed wait brief
  rtu_io_sampling_sequencer #(.MS_TICKS(4)) i_dut (.*);
  field_side_model i_field (
    .i_clock(i_clock),
    .i_start(o_adc_start),
    .i_channel(o_adc_channel),
    .i_slow(slow),
    .o_done(i_adc_done),
    .o_data(i_adc_data)
  );
  initial
  begin
    forever #25 i_clock = ~i_clock;
  end
  ////////////////////////////////////////
  task automatic report_and_stop();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge i_clock);
  endtask
  task automatic wait_on(ref logic s, input logic v, input int n, output int k);
    for (k = 0; s !== v; k++)
    begin
      if (k == n)
      begin
        fails++;
        report_and_stop();
      end
      step(1);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    i_addr <= a;
    i_wr_data <= d;
    i_wr_en <= 1'b1;
    step(1);
    i_wr_en <= 1'b0;
    step(1);
  endtask
  task automatic rget(input logic [7:0] a, output logic [31:0] d);
    i_addr <= a;
    i_rd_en <= 1'b1;
    step(1);
    i_rd_en <= 1'b0;
    #1 d = o_rd_data;
    step(1);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rget(a, d);
    cmp(d, exp);
  endtask
  function automatic logic [31:0] outs();
    return {26'h0, o_high_side_output, o_high_side_output_oe_n, o_low_side_output_a,
      o_low_side_output_a_oe_n, o_low_side_output_b, o_low_side_output_b_oe_n};
  endfunction
  ////////////////////////////////////////
  task automatic test_regs();
    rchk(ADDR_SETTLE, 32'h190);
    rchk(ADDR_PERIOD, 32'h1388);
    rchk(ADDR_HOLD, 32'h493e0);
    rchk(8'hff, 32'h0);
    $display("register test done");
  endtask
  task automatic seq(input int fall_max, output longint t);
    int k;
    wait_on(o_sensor_supply, 1'b1, 700, k);
    t = $time;
    wait_on(o_adc_start, 1'b1, 20, k);
    // Three 4-cycle ms ticks of settle plus two cycles of pipeline
    cmp(32'(k), 32'he);
    for (int i = 0; i < 5; i++)
    begin
      wait_on(o_adc_start, 1'b1, 40, k);
      cmp({29'h0, o_adc_channel}, 32'(i));
      cmp(32'(o_supply_indicator), 32'h1);
      step(1);
    end
    wait_on(o_sensor_supply, 1'b0, fall_max, k);
    cmp(32'(o_supply_indicator), 32'h0);
  endtask
  task automatic test_sample();
    longint t0;
    longint t1;
    wreg(ADDR_SETTLE, 32'h3);
    wreg(ADDR_PERIOD, 32'h28);
    seq(8, t0);
    slow <= 1'b1;
    seq(18, t1);
    cmp(32'((t1 - t0) / 50), 32'ha0);
    rchk(8'h20, 32'h0);
    rchk(8'h21, 32'h50);
    rchk(8'h22, 32'ha);
    rchk(8'h31, 32'h890);
    $display("sample test done");
  endtask
  task automatic test_hold();
    int k;
    wreg(ADDR_PERIOD, 32'hea60);
    wreg(ADDR_HOLD, 32'h14);
    i_rx_activity <= 1'b1;
    i_tx_activity <= 1'b1;
    step(4);
    cmp({30'h0, o_rx_indicator, o_tx_indicator}, 32'h0);
    i_test_button <= 1'b1;
    wait_on(o_sensor_supply, 1'b1, 4, k);
    rchk(ADDR_STATUS, 32'h300);
    step(70);
    cmp({29'h0, o_rx_indicator, o_tx_indicator, o_supply_indicator}, 32'h7);
    i_test_button <= 1'b0;
    wait_on(o_sensor_supply, 1'b0, 16, k);
    cmp({30'h0, o_rx_indicator, o_tx_indicator}, 32'h0);
    $display("hold test done");
  endtask
  task automatic closure(output longint t);
    i_status_in[1] <= 1'b0;
    step(4);
    i_status_in[1] <= 1'b1;
    t = $time;
    step(4);
  endtask
  task automatic test_status();
    longint t1;
    longint t2;
    logic [31:0] s1;
    logic [31:0] s2;
    wreg(ADDR_DI_CFG, 32'hd);
    wreg(ADDR_LIMIT, 32'h2);
    wreg(ADDR_TS_INDEX, 32'h1);
    i_status_in <= 8'h0f;
    step(12);
    rchk(ADDR_STATUS, 32'hf1);
    wreg(ADDR_EVENTS, 32'hff);
    closure(t1);
    rget(ADDR_TS_DATA, s1);
    rchk(ADDR_EVENTS, 32'h0);
    closure(t2);
    rget(ADDR_TS_DATA, s2);
    // One ms is four 50 ns cycles here; stamps may differ by one tick
    cmp(32'((s2 - s1 + 32'h1 - 32'((t2 - t1) / 200)) <= 32'h2), 32'h1);
    rchk(ADDR_EVENTS, 32'h2);
    rchk(8'h11, 32'h2);
    $display("status test done");
  endtask
  // Bad order takes Y low before Z
  task automatic kyz(input int z, input logic good);
    i_status_in[good ? z : z + 1] <= 1'b0;
    step(3);
    i_status_in[good ? z + 1 : z] <= 1'b0;
    step(3);
    i_status_in[z] <= 1'b1;
    step(3);
    i_status_in[z + 1] <= 1'b1;
    step(3);
  endtask
  task automatic test_pulse();
    i_status_in <= 8'hff;
    wreg(ADDR_CTRL, 32'h18);
    kyz(4, 1'b1);
    kyz(4, 1'b0);
    kyz(6, 1'b1);
    kyz(6, 1'b1);
    rchk(ADDR_PAIR1_COUNT, 32'h1);
    rchk(ADDR_PAIR2_COUNT, 32'h2);
    $display("pulse test done");
  endtask
  task automatic test_outputs();
    wreg(ADDR_CTRL, 32'h7);
    step(1);
    cmp(outs(), 32'h20);
    wreg(ADDR_CTRL, 32'h0);
    step(1);
    cmp(outs(), 32'h15);
    wreg(ADDR_MOMENT, 32'h2);
    wreg(ADDR_PULSE_CMD, 32'h2);
    step(1);
    cmp(outs(), 32'h14);
    step(12);
    cmp(outs(), 32'h15);
    $display("output test done");
  endtask
  initial
  begin
    step(8);
    i_reset_n <= 1'b1;
    step(1);
    test_regs();
    test_sample();
    test_hold();
    test_status();
    test_pulse();
    test_outputs();
    report_and_stop();
  end
endmodule
`default_nettype wire
